// file: dsr_regs.vh
/*
 holds offsets, field positions, reset values and mode codes of the status bank.
 assumes inclusion by the status bank files only.
*/
`ifndef DSR_REGS_VH
`define DSR_REGS_VH
`define DSR_ADDR_CHAN_PWR 8'h79
`define DSR_ADDR_STATE_FLT 8'h7a
`define DSR_RST_CHAN_PWR 8'h00
`define DSR_RST_STATE_FLT 8'h80
`define DSR_MODE_MSB 7
`define DSR_MODE_LSB 5
`define DSR_BIT_PLL 4
`define DSR_BIT_MICB 3
`define DSR_BIT_RSVD 2
`define DSR_BIT_INFLT 1
`define DSR_BIT_BIASFLT 0
`define DSR_MODE_SLEEP 3'h4
`define DSR_MODE_IDLE 3'h6
`define DSR_MODE_ACTIVE 3'h7
`define DSR_NCH 4
`endif

// file: dsr_chan_pwr.v
/*
 one group of four converter channels: powered state per channel.
 assumes enables and fault off come from same-clock logic.
*/
`timescale 1ns/1ps
`default_nettype none
module dsr_chan_pwr (
  input wire clk_i,
  input wire rst_b_i,
  input wire pwr_ctrl_i,
  input wire [3:0] chan_en_i,
  input wire [3:0] chan_fault_off_i,
  output reg [3:0] powered_o
);
  // faulted channels stay off even with control set
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      powered_o <= 4'h0;
    end else if (pwr_ctrl_i) begin
      powered_o <= chan_en_i & ~chan_fault_off_i;
    end else begin
      powered_o <= 4'h0;
    end
  end
endmodule
`default_nettype wire

// file: dsr_mode_code.v
/*
 derives the operating state code from sleep and channel power state.
 assumes inputs are registered on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dsr_regs.vh"
module dsr_mode_code (
  input wire clk_i,
  input wire rst_b_i,
  input wire sleep_i,
  input wire any_chan_on_i,
  output reg [2:0] operating_state_code_o
);
  reg [2:0] code_d;
  always @* begin
    if (sleep_i) begin
      code_d = `DSR_MODE_SLEEP;
    end else if (any_chan_on_i) begin
      code_d = `DSR_MODE_ACTIVE;
    end else begin
      code_d = `DSR_MODE_IDLE;
    end
  end
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      operating_state_code_o <= `DSR_MODE_SLEEP;
    end else begin
      operating_state_code_o <= code_d;
    end
  end
endmodule
`default_nettype wire

// file: dsr_status_bank.v
/*
 read-only device status bank: channel power and device state/fault registers.
 assumes a control-port engine presenting address, read and write strobes on clk_i,
 and power/fault/pll/bias inputs from same-clock logic.
*/
//
// Function
// - record channel power states in bits 7..4, channel one at bit 7.
// - playback channel power states in bits 3..0, channel one at bit 3.
// - mode field bits 7..5: 4 sleep, 6 idle active, 7 channels on.
// - state and fault register resets to 0x80, mode reads sleep.
// - bit 4 reads 1 while the synthesiser loop is enabled.
// - bit 3 reads 1 while the microphone supply is enabled.
// - bit 2 reserved, reads 0, writes never change it.
// - bit 1 set when some record channel forced off by input fault.
// - bit 0 set when all record channels forced off by bias fault.
// - record power control powers enabled record channels, clearing powers all down.
// - playback power control powers enabled playback channels, clearing powers all down.
`timescale 1ns/1ps
`default_nettype none
`include "dsr_regs.vh"
module dsr_status_bank (
  input wire clk_i,
  input wire rst_b_i,
  input wire [7:0] reg_addr_i,
  input wire reg_rd_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  output wire reg_hit_o,
  input wire record_power_control_i,
  input wire playback_power_control_i,
  input wire [3:0] rec_chan_en_i,
  input wire [3:0] play_chan_en_i,
  input wire [3:0] rec_input_fault_i,
  input wire bias_fault_i,
  input wire sleep_i,
  input wire synth_loop_en_i,
  input wire mic_supply_en_i,
  output wire [3:0] rec_powered_o,
  output wire [3:0] play_powered_o
);
  wire [3:0] rec_pwr;
  wire [3:0] play_pwr;
  wire [3:0] rec_fault_off;
  wire [2:0] operating_state_code;
  reg synth_loop_running_q;
  reg mic_supply_on_q;
  reg input_fault_shutdown_flag_q;
  reg bias_fault_total_shutdown_flag_q;
  wire [7:0] channel_power_status;
  wire [7:0] device_state_and_fault_status;

  // bias fault kills every record channel; input faults kill their own
  assign rec_fault_off = rec_input_fault_i | {4{bias_fault_i}};

  // record group gated by its own power control
  dsr_chan_pwr u_rec (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .pwr_ctrl_i(record_power_control_i & ~sleep_i),
    .chan_en_i(rec_chan_en_i),
    .chan_fault_off_i(rec_fault_off),
    .powered_o(rec_pwr)
  );

  dsr_chan_pwr u_play (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .pwr_ctrl_i(playback_power_control_i & ~sleep_i),
    .chan_en_i(play_chan_en_i),
    .chan_fault_off_i(4'h0),
    .powered_o(play_pwr)
  );

  dsr_mode_code u_mode (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .sleep_i(sleep_i),
    .any_chan_on_i(|{rec_pwr, play_pwr}),
    .operating_state_code_o(operating_state_code)
  );

  // registered so these flags line up one cycle after their cause; the mode field lags a power control change by two cycles
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      synth_loop_running_q <= 1'b0;
      mic_supply_on_q <= 1'b0;
      input_fault_shutdown_flag_q <= 1'b0;
      bias_fault_total_shutdown_flag_q <= 1'b0;
    end else begin
      synth_loop_running_q <= synth_loop_en_i;
      mic_supply_on_q <= mic_supply_en_i;
      // only counts while record power is requested, else nothing was forced off
      input_fault_shutdown_flag_q <= record_power_control_i & (|(rec_input_fault_i & rec_chan_en_i));
      bias_fault_total_shutdown_flag_q <= record_power_control_i & bias_fault_i;
    end
  end

  assign rec_powered_o = rec_pwr;
  assign play_powered_o = play_pwr;

  // channel one sits in the highest bit of each nibble
  assign channel_power_status = {rec_pwr[0], rec_pwr[1], rec_pwr[2], rec_pwr[3],
    play_pwr[0], play_pwr[1], play_pwr[2], play_pwr[3]};

  assign device_state_and_fault_status = {operating_state_code, synth_loop_running_q,
    mic_supply_on_q, 1'b0, input_fault_shutdown_flag_q,
    bias_fault_total_shutdown_flag_q};

  assign reg_hit_o = (reg_addr_i == `DSR_ADDR_CHAN_PWR) ||
    (reg_addr_i == `DSR_ADDR_STATE_FLT);

  // writes are accepted by the port but never reach any status bit
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `DSR_ADDR_CHAN_PWR: reg_rdata_o <= channel_power_status;
        `DSR_ADDR_STATE_FLT: reg_rdata_o <= device_state_and_fault_status;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  wire unused_ok = reg_wr_i ^ (^reg_wdata_i);
endmodule
`default_nettype wire

// file: dsr_status_bank_properties.sv
/* status bank port checker.
 assumes one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module dsr_status_bank_properties (
  input wire clk_i, rst_b_i, reg_rd_i, reg_hit_o, bias_fault_i, synth_loop_en_i, mic_supply_en_i,
  input wire [7:0] reg_addr_i, reg_rdata_o);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire r7a = reg_rd_i && reg_addr_i == 8'h7a;
  AST_PL: assert property (r7a && $past(rst_b_i) |=>
    reg_rdata_o[4] == $past(synth_loop_en_i, 2)) else $error("pll");
  AST_MC: assert property (r7a && $past(rst_b_i) |=>
    reg_rdata_o[3] == $past(mic_supply_en_i, 2)) else $error("mic");
  AST_BF: assert property (r7a && !$past(bias_fault_i) |=>
    !reg_rdata_o[0]) else $error("bias");
  AST_MD: assert property (r7a |=> reg_rdata_o[7] && reg_rdata_o[7:5] != 3'h5)
    else $error("mode");
  AST_RS: assert property (r7a |=> !reg_rdata_o[2]) else $error("rsvd");
  AST_UN: assert property (reg_rd_i && !reg_hit_o |=> !reg_rdata_o)
    else $error("unmap");
  AST_HD: assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("hold");
  AST_HT: assert property (reg_hit_o == (reg_addr_i inside {8'h79, 8'h7a}))
    else $error("hit");
  cover property (r7a);
  cover property (reg_rd_i && !reg_hit_o);
  cover property (r7a ##1 reg_rdata_o[0]);
endmodule
bind dsr_status_bank dsr_status_bank_properties u_prop (.*);
`default_nettype wire

// file: tb.sv
/* status bank random read test.
 assumes one-cycle read latency. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i = 0, rst_b_i = 0, rd = 0, wr = 0, hit, rc, pc, bf, sl, pl, mc;
  logic [7:0] ad, q, ra;
  logic [7:0] wd = 0;
  logic [3:0] re, pe, rf, rp, pp;
  int miscompares = 0, compares = 0;
  always #5 clk_i = ~clk_i;
  dsr_status_bank u_dsr_status_bank (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(ad),
    .reg_rd_i(rd), .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rdata_o(q), .reg_hit_o(hit),
    .record_power_control_i(rc), .playback_power_control_i(pc), .rec_chan_en_i(re),
    .play_chan_en_i(pe), .rec_input_fault_i(rf), .bias_fault_i(bf), .sleep_i(sl),
    .synth_loop_en_i(pl), .mic_supply_en_i(mc), .rec_powered_o(rp), .play_powered_o(pp));
  // powered ports keep channel one at bit 0, record group on top
  function logic [7:0] epw();
    return {re & ~rf & {4{rc & ~sl & ~bf}}, pe & {4{pc & ~sl}}};
  endfunction
  function logic [7:0] e79();
    e79 = {<<{pe & {4{pc & ~sl}}, re & ~rf & {4{rc & ~sl & ~bf}}}};
  endfunction
  function logic [7:0] e7a();
    return {sl ? 3'h4 : |e79() ? 3'h7 : 3'h6, pl, mc, 1'b0, rc & |(rf & re), rc & bf};
  endfunction
  function logic [7:0] eat(logic [7:0] a);
    return a == 8'h79 ? e79() : a == 8'h7a ? e7a() : 8'h00;
  endfunction
  task rdc(logic [7:0] a, e);
    @(posedge clk_i) #1;
    ad = a;
    rd = 1;
    @(posedge clk_i) #1;
    rd = 0;
    compares++;
    if (q !== e) begin
      miscompares++;
      $display("wrong value rdata exp %h got %h", e, q);
    end
    compares++;
    if (hit !== (a == 8'h79 || a == 8'h7a)) begin
      miscompares++;
      $display("wrong value reg_hit exp %b got %b", a == 8'h79 || a == 8'h7a, hit);
    end
  endtask
  task pwc(logic [7:0] e);
    compares++;
    if ({rp, pp} !== e) begin
      miscompares++;
      $display("wrong value powered exp %h got %h", e, {rp, pp});
    end
  endtask
  task stop_test();
    if (miscompares == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    // sleep held so the mode field keeps its reset code
    {rc, pc, bf, pl, mc, re, pe, rf, ad, sl} = 1;
    void'($urandom(54));
    repeat (5) @(posedge clk_i);
    #1 rst_b_i = 1;
    rdc(8'h7a, 8'h80);
    rdc(8'h33, 8'h00);
    repeat (150) begin
      // writes run at random too, they must never show in a read
      {rc, pc, bf, sl, pl, mc, re, pe, rf, wr, wd} = 27'($urandom);
      ra = 8'($urandom);
      // mode trails power by a cycle, so let both settle
      repeat (3) @(posedge clk_i);
      pwc(epw());
      rdc(8'h79, e79());
      rdc(8'h7a, e7a());
      rdc(ra, eat(ra));
    end
    // reset mid-run: powered state must clear without waiting for an edge
    rst_b_i = 0;
    {rc, pc, bf, pl, mc, re, pe, rf, ad, sl} = 1;
    #1 pwc(8'h00);
    @(posedge clk_i) #1;
    rst_b_i = 1;
    rdc(8'h7a, 8'h80);
    rdc(8'h79, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
